// *** verilog/crcchk_defs.svh ***
// constants of the rom checksum checker: register offsets, bit positions, reset values
// assumes a 32-bit ahb-lite slave with one byte-wide register per aligned word
`ifndef CRCCHK_DEFS_SVH
`define CRCCHK_DEFS_SVH

`define CRCCHK_OFS_CTRL 8'h00
`define CRCCHK_OFS_DIN 8'h04
`define CRCCHK_OFS_DR 8'h08
`define CRCCHK_OFS_BEG 8'h0c
`define CRCCHK_OFS_CNT 8'h10
`define CRCCHK_OFS_ISTAT 8'h14
`define CRCCHK_OFS_IMASK 8'h18

`define CRCCHK_CTRL_PTR 0
`define CRCCHK_CTRL_START 1
`define CRCCHK_CTRL_SEL 2
`define CRCCHK_CTRL_SEED 3
`define CRCCHK_CTRL_DONE 4

`define CRCCHK_IRQ_SCAN 0
`define CRCCHK_IRQ_BYTE 1

`define CRCCHK_POLY 16'h1021
`define CRCCHK_SEED0 16'h0000
`define CRCCHK_SEED1 16'hffff
`define CRCCHK_LAST_SECT 7'h7f
`define CRCCHK_SECT_LAST_BYTE 7'h7f
`define CRCCHK_SECT_FIRST_BYTE 7'h00
`define CRCCHK_RST_CRC 16'h0000

`endif

// *** verilog/crcchk_pkg.sv ***
// types of the rom checksum checker and its byte fold function
// assumes crcchk_defs.svh is on the include path
`include "crcchk_defs.svh"

package crcchk_pkg;

  typedef enum logic [1:0] {
    S_IDLE,
    S_RUN,
    S_DRAIN
  } crcchk_phase_t;

  typedef struct packed {
    logic rd;
    logic [13:0] addr;
  } crcchk_rom_req_t;

  typedef struct packed {
    logic [15:0] crc;
    logic ptr;
    logic seed_sel;
    crcchk_phase_t phase;
    logic [6:0] beg;
    logic [6:0] cnt;
    logic [13:0] addr;
    logic [13:0] last;
    logic fold;
    logic [1:0] istat;
    logic [1:0] imask;
    logic dp_act;
    logic dp_wr;
    logic [7:0] dp_ofs;
    logic rd_rdy;
    logic [7:0] rdata;
  } crcchk_state_t;

  // msb-first byte fold, unrolled by the tools into one cycle of xor logic
  function automatic logic [15:0] crcchk_fold(input logic [15:0] crc, input logic [7:0] din);
    logic [15:0] c;
    logic fb;
    c = crc;
    fb = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      fb = c[15] ^ din[i];
      c = {c[14:0], 1'b0} ^ (fb ? `CRCCHK_POLY : 16'h0000);
    end
    return c;
  endfunction

endpackage

// *** verilog/crcchk_top.sv ***
// rom checksum checker: ccitt-false crc engine with byte port and automatic rom sector scan
// assumes one ahb-lite master, a rom read port answering one cycle after rom_req.rd,
// and a processor that honours cpu_stall
//
// Overview of operation
// - checksum generator polynomial is 0x1021
// - one whole byte folded per clock
// - byte port write folds byte into checksum
// - byte port keeps nothing, reads zero
// - seed load gives 0x0000 or 0xffff
// - seed trigger pulses once, always reads zero
// - result window follows pointer, low or high
// - any seed preloadable through result window
// - scan start folds rom bytes into checksum
// - rom is 128 sectors of 128 bytes
// - scan begins at first sector times 128
// - last sector is first plus offset
// - scan past sector 127 is clamped
// - complete flag low only while scanning
// - processor stalls for whole scan
//
// Implementation choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "crcchk_defs.svh"

module crcchk_top (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // rom read port
  output crcchk_pkg::crcchk_rom_req_t rom_req,
  input wire logic [7:0] rom_data,
  // system
  output logic cpu_stall,
  output logic irq
);

  crcchk_pkg::crcchk_state_t q, d;

  logic busy;
  logic wr_go;
  logic rd_go;
  logic [7:0] w;
  logic [7:0] end_sum;
  logic [6:0] end_sect;
  logic [7:0] rd_mux;
  logic [1:0] ev;

  assign busy = (q.phase != crcchk_pkg::S_IDLE);
  // a write waits out a running scan; a read waits out a scan too, then takes one wait state so it sees
  // the effect of a write that completed in the cycle before
  assign wr_go = q.dp_act && q.dp_wr && !busy;
  assign rd_go = q.dp_act && !q.dp_wr && q.rd_rdy;
  assign hreadyout = !q.dp_act || wr_go || rd_go;
  assign hresp = 1'b0;
  assign hrdata = {24'h000000, q.rdata};
  assign w = hwdata[7:0];
  assign cpu_stall = busy;
  assign irq = |(q.istat & q.imask);
  assign rom_req.rd = (q.phase == crcchk_pkg::S_RUN);
  assign rom_req.addr = q.addr;

  // end sector: eighth bit of the sum means the range ran past the last sector
  assign end_sum = {1'b0, q.beg} + {1'b0, q.cnt};
  assign end_sect = end_sum[7] ? `CRCCHK_LAST_SECT : end_sum[6:0];

  always_comb begin
    rd_mux = 8'h00;
    unique case (q.dp_ofs)
      `CRCCHK_OFS_CTRL: begin
        rd_mux[`CRCCHK_CTRL_PTR] = q.ptr;
        rd_mux[`CRCCHK_CTRL_START] = busy;
        rd_mux[`CRCCHK_CTRL_SEL] = q.seed_sel;
        rd_mux[`CRCCHK_CTRL_SEED] = 1'b0;
        rd_mux[`CRCCHK_CTRL_DONE] = !busy;
      end
      `CRCCHK_OFS_DIN: rd_mux = 8'h00;
      `CRCCHK_OFS_DR: rd_mux = q.ptr ? q.crc[15:8] : q.crc[7:0];
      `CRCCHK_OFS_BEG: rd_mux = {1'b0, q.beg};
      `CRCCHK_OFS_CNT: rd_mux = {1'b0, q.cnt};
      `CRCCHK_OFS_ISTAT: rd_mux = {6'h00, q.istat};
      `CRCCHK_OFS_IMASK: rd_mux = {6'h00, q.imask};
      default: rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    d = q;
    ev = 2'b00;

    // bus data phase
    if (q.dp_act && !q.dp_wr && !q.rd_rdy && !busy) begin
      d.rdata = rd_mux;
      d.rd_rdy = 1'b1;
    end
    if (hreadyout) begin
      d.dp_act = 1'b0;
    end

    if (wr_go) begin
      unique case (q.dp_ofs)
        `CRCCHK_OFS_CTRL: begin
          d.ptr = w[`CRCCHK_CTRL_PTR];
          d.seed_sel = w[`CRCCHK_CTRL_SEL];
          // the trigger is not stored: it acts only in the write cycle
          if (w[`CRCCHK_CTRL_SEED]) begin
            d.crc = w[`CRCCHK_CTRL_SEL] ? `CRCCHK_SEED1 : `CRCCHK_SEED0;
          end
          // start uses range registers written earlier, not this write's bits
          if (w[`CRCCHK_CTRL_START]) begin
            d.phase = crcchk_pkg::S_RUN;
            d.addr = {q.beg, `CRCCHK_SECT_FIRST_BYTE};
            d.last = {end_sect, `CRCCHK_SECT_LAST_BYTE};
          end
        end
        `CRCCHK_OFS_DIN: begin
          d.crc = crcchk_pkg::crcchk_fold(q.crc, w);
          ev[`CRCCHK_IRQ_BYTE] = 1'b1;
        end
        `CRCCHK_OFS_DR: begin
          if (q.ptr) begin
            d.crc[15:8] = w;
          end else begin
            d.crc[7:0] = w;
          end
        end
        `CRCCHK_OFS_BEG: d.beg = w[6:0];
        `CRCCHK_OFS_CNT: d.cnt = w[6:0];
        `CRCCHK_OFS_ISTAT: d.istat = q.istat & ~w[1:0];
        `CRCCHK_OFS_IMASK: d.imask = w[1:0];
        default: d.dp_act = 1'b0;
      endcase
    end

    // new address phase
    if (hsel && htrans[1] && hready) begin
      d.dp_act = 1'b1;
      d.dp_wr = hwrite;
      d.dp_ofs = {haddr[7:2], 2'b00};
      d.rd_rdy = 1'b0;
    end

    // rom scan: one read issued per cycle, folded when the data returns
    d.fold = (q.phase == crcchk_pkg::S_RUN);
    if (q.fold) begin
      d.crc = crcchk_pkg::crcchk_fold(q.crc, rom_data);
    end
    unique case (q.phase)
      crcchk_pkg::S_IDLE: begin
      end
      crcchk_pkg::S_RUN: begin
        if (q.addr == q.last) begin
          d.phase = crcchk_pkg::S_DRAIN;
        end else begin
          d.addr = q.addr + 14'h0001;
        end
      end
      crcchk_pkg::S_DRAIN: begin
        d.phase = crcchk_pkg::S_IDLE;
        ev[`CRCCHK_IRQ_SCAN] = 1'b1;
      end
    endcase

    // an event in the clearing cycle wins over the clear
    d.istat = d.istat | ev;
  end

  // all-zero reset: idle, seed zero, flags and masks clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_wr(logic [7:0] ofs);
    wr_go && q.dp_ofs == ofs;
  endsequence

  sequence s_rd(logic [7:0] ofs);
    rd_go && q.dp_ofs == ofs;
  endsequence

  property p_din_fold;
    s_wr(`CRCCHK_OFS_DIN) |=> q.crc == crcchk_pkg::crcchk_fold($past(q.crc), $past(w));
  endproperty
  a_din_fold: assert property (p_din_fold) else $error("byte port fold wrong");

  property p_fold_one_cycle;
    s_wr(`CRCCHK_OFS_DIN) ##2 s_wr(`CRCCHK_OFS_DIN) |=> q.crc ==
      crcchk_pkg::crcchk_fold(crcchk_pkg::crcchk_fold($past(q.crc, 3), $past(w, 3)), $past(w));
  endproperty
  a_fold_one_cycle: assert property (p_fold_one_cycle) else $error("back to back bytes lost");

  property p_poly;
    s_wr(`CRCCHK_OFS_DIN) ##0 (q.crc == 16'h0000 && w == 8'h01) |=> q.crc == 16'h1021;
  endproperty
  a_poly: assert property (p_poly) else $error("generator polynomial wrong");

  property p_din_zero;
    s_rd(`CRCCHK_OFS_DIN) |-> hrdata == 32'h00000000;
  endproperty
  a_din_zero: assert property (p_din_zero) else $error("byte port read not zero");

  property p_seed;
    s_wr(`CRCCHK_OFS_CTRL) ##0 w[`CRCCHK_CTRL_SEED] |=>
      q.crc == ($past(w[`CRCCHK_CTRL_SEL]) ? 16'hffff : 16'h0000);
  endproperty
  a_seed: assert property (p_seed) else $error("seed load wrong");

  property p_trig_zero;
    s_rd(`CRCCHK_OFS_CTRL) |-> !hrdata[`CRCCHK_CTRL_SEED];
  endproperty
  a_trig_zero: assert property (p_trig_zero) else $error("seed trigger read as one");

  property p_window_rd;
    s_rd(`CRCCHK_OFS_DR) |-> hrdata[7:0] == (q.ptr ? q.crc[15:8] : q.crc[7:0]);
  endproperty
  a_window_rd: assert property (p_window_rd) else $error("result window read wrong");

  property p_window_wr;
    s_wr(`CRCCHK_OFS_DR) |=> ($past(q.ptr) ? q.crc[15:8] : q.crc[7:0]) == $past(w);
  endproperty
  a_window_wr: assert property (p_window_wr) else $error("result window write wrong");

  property p_scan_start;
    s_wr(`CRCCHK_OFS_CTRL) ##0 w[`CRCCHK_CTRL_START] |=>
      rom_req.rd && rom_req.addr == {$past(q.beg), 7'h00};
  endproperty
  a_scan_start: assert property (p_scan_start) else $error("scan start address wrong");

  property p_scan_last;
    busy |-> q.last == {end_sect, 7'h7f} && end_sect >= q.beg;
  endproperty
  a_scan_last: assert property (p_scan_last) else $error("scan end sector wrong");

  property p_ascend;
    rom_req.rd && $past(rom_req.rd) |-> rom_req.addr == $past(rom_req.addr) + 14'h0001;
  endproperty
  a_ascend: assert property (p_ascend) else $error("rom fetch not ascending");

  property p_rom_fold;
    rom_req.rd |=> q.fold ##1 q.crc == crcchk_pkg::crcchk_fold($past(q.crc), $past(rom_data));
  endproperty
  a_rom_fold: assert property (p_rom_fold) else $error("rom byte not folded");

  property p_done_flag;
    s_rd(`CRCCHK_OFS_CTRL) |-> hrdata[`CRCCHK_CTRL_DONE] == !cpu_stall;
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("complete flag wrong");

  property p_stall;
    $fell(busy) |-> $past(q.phase) == crcchk_pkg::S_DRAIN && $past(rom_req.addr, 2) == $past(q.last);
  endproperty
  a_stall: assert property (p_stall) else $error("stall ended before scan end");

  sequence s_start;
    s_wr(`CRCCHK_OFS_CTRL) ##0 w[`CRCCHK_CTRL_START];
  endsequence

  sequence s_last_fetch;
    rom_req.rd && rom_req.addr == q.last;
  endsequence

  sequence s_wind_down;
    !rom_req.rd && cpu_stall ##1 !cpu_stall;
  endsequence

  property p_seed_zero;
    s_wr(`CRCCHK_OFS_CTRL) ##0 (w[`CRCCHK_CTRL_SEED] && !w[`CRCCHK_CTRL_SEL]) |=> q.crc == `CRCCHK_SEED0;
  endproperty
  a_seed_zero: assert property (p_seed_zero) else $error("zero seed not loaded");

  property p_seed_ones;
    s_wr(`CRCCHK_OFS_CTRL) ##0 (w[`CRCCHK_CTRL_SEED] && w[`CRCCHK_CTRL_SEL]) |=> q.crc == `CRCCHK_SEED1;
  endproperty
  a_seed_ones: assert property (p_seed_ones) else $error("all ones seed not loaded");

  property p_sel_wr;
    s_wr(`CRCCHK_OFS_CTRL) |=> q.seed_sel == $past(w[`CRCCHK_CTRL_SEL]);
  endproperty
  a_sel_wr: assert property (p_sel_wr) else $error("seed select not stored");

  property p_ptr_wr;
    s_wr(`CRCCHK_OFS_CTRL) |=> q.ptr == $past(w[`CRCCHK_CTRL_PTR]);
  endproperty
  a_ptr_wr: assert property (p_ptr_wr) else $error("byte pointer not stored");

  property p_window_lo;
    s_wr(`CRCCHK_OFS_DR) ##0 !q.ptr |=> q.crc == {$past(q.crc[15:8]), $past(w)};
  endproperty
  a_window_lo: assert property (p_window_lo) else $error("low half preload wrong");

  property p_window_hi;
    s_wr(`CRCCHK_OFS_DR) ##0 q.ptr |=> q.crc == {$past(w), $past(q.crc[7:0])};
  endproperty
  a_window_hi: assert property (p_window_hi) else $error("high half preload wrong");

  property p_clamp;
    busy && ({1'b0, q.beg} + {1'b0, q.cnt}) > 8'h7f |-> q.last == 14'h3fff;
  endproperty
  a_clamp: assert property (p_clamp) else $error("overlong range not clamped");

  property p_no_clamp;
    busy && ({1'b0, q.beg} + {1'b0, q.cnt}) <= 8'h7f |-> q.last == {q.beg + q.cnt, 7'h7f};
  endproperty
  a_no_clamp: assert property (p_no_clamp) else $error("range end not first plus offset");

  property p_one_sector;
    s_wr(`CRCCHK_OFS_CTRL) ##0 (w[`CRCCHK_CTRL_START] && q.cnt == 7'h00) |=> q.last == {$past(q.beg), 7'h7f};
  endproperty
  a_one_sector: assert property (p_one_sector) else $error("zero offset not one sector");

  property p_addr_in_range;
    busy |-> q.addr <= q.last;
  endproperty
  a_addr_in_range: assert property (p_addr_in_range) else $error("fetch past range end");

  property p_sect_align;
    s_start |=> rom_req.addr[6:0] == 7'h00 && q.last[6:0] == 7'h7f;
  endproperty
  a_sect_align: assert property (p_sect_align) else $error("scan not sector aligned");

  property p_stall_start;
    s_start |=> cpu_stall && rom_req.rd;
  endproperty
  a_stall_start: assert property (p_stall_start) else $error("stall late at scan start");

  property p_scan_end;
    s_last_fetch |=> s_wind_down;
  endproperty
  a_scan_end: assert property (p_scan_end) else $error("scan did not wind down");

  property p_last_fold;
    $fell(busy) |-> q.crc == crcchk_pkg::crcchk_fold($past(q.crc), $past(rom_data));
  endproperty
  a_last_fold: assert property (p_last_fold) else $error("last rom byte not folded");

  property p_scan_event;
    $fell(busy) |-> q.istat[`CRCCHK_IRQ_SCAN];
  endproperty
  a_scan_event: assert property (p_scan_event) else $error("scan end event missing");

  property p_rd_done;
    s_rd(`CRCCHK_OFS_CTRL) |-> hrdata[`CRCCHK_CTRL_DONE];
  endproperty
  a_rd_done: assert property (p_rd_done) else $error("complete flag low when idle");

  property p_byte_event;
    s_wr(`CRCCHK_OFS_DIN) |=> q.istat[`CRCCHK_IRQ_BYTE];
  endproperty
  a_byte_event: assert property (p_byte_event) else $error("byte event missing");

  property p_crc_hold;
    !busy && !wr_go |=> q.crc == $past(q.crc);
  endproperty
  a_crc_hold: assert property (p_crc_hold) else $error("checksum changed without cause");

  property p_beg_wr;
    s_wr(`CRCCHK_OFS_BEG) |=> q.beg == $past(w[6:0]);
  endproperty
  a_beg_wr: assert property (p_beg_wr) else $error("first sector not stored");

  property p_cnt_wr;
    s_wr(`CRCCHK_OFS_CNT) |=> q.cnt == $past(w[6:0]);
  endproperty
  a_cnt_wr: assert property (p_cnt_wr) else $error("sector offset not stored");

endmodule // crcchk_top

`default_nettype wire

// *** test/crcchk_rom_model.sv ***
// behavioural model of the program rom read port seen by the checksum checker
// assumes one byte is answered in the cycle after each read strobe
`timescale 1ns/10ps
`default_nettype none

module crcchk_rom_model (
  // clock
  input wire logic hclk,
  // rom read port
  input wire crcchk_pkg::crcchk_rom_req_t rom_req,
  output logic [7:0] rom_data
);
  initial rom_data = 8'h00;
  // content is a function of the 14-bit byte address so the bench can predict every byte
  always @(posedge hclk) begin
    if (rom_req.rd === 1'b1) begin
      rom_data <= rom_req.addr[7:0] ^ {rom_req.addr[13:8], 2'b01};
    end else begin
      // no fetch: the port must not keep showing the last byte
      rom_data <= ~rom_data;
    end
  end
endmodule // crcchk_rom_model
`default_nettype wire

// *** test/tb_top.sv ***
// self-checking bench of the rom checksum checker, driven over ahb-lite
// assumes crcchk_top, crcchk_rom_model and crcchk_defs.svh are compiled alongside
`timescale 1ns/10ps
`default_nettype none
`include "crcchk_defs.svh"

module tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b1;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] haddr = 32'h00000000;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, cpu_stall, irq;
  logic [7:0] rom_data;
  logic [13:0] first_a, next_a;
  logic [15:0] crc_e;
  crcchk_pkg::crcchk_rom_req_t rom_req;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int n_rd = 0;

  crcchk_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .rom_req(rom_req), .rom_data(rom_data), .cpu_stall(cpu_stall),
    .irq(irq));
  crcchk_rom_model rom (.hclk(hclk), .rom_req(rom_req), .rom_data(rom_data));

  initial forever #5 hclk = ~hclk;

  // independent msb-first fold and rom content
  function automatic logic [15:0] f(input logic [15:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `CRCCHK_POLY : 16'h0000);
    return c;
  endfunction
  function automatic logic [7:0] rom_byte(input logic [13:0] a);
    return a[7:0] ^ {a[13:8], 2'b01};
  endfunction

  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // one single transfer; entered just after a rising edge, left at the edge ending the data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] wd);
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h000000, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(rd, {24'h000000, e});
  endtask
  task automatic rdcrc();
    rdchk(`CRCCHK_OFS_DR, crc_e[7:0]);
    wr(`CRCCHK_OFS_CTRL, 8'h01);
    rdchk(`CRCCHK_OFS_DR, crc_e[15:8]);
    wr(`CRCCHK_OFS_CTRL, 8'h00);
  endtask
  task automatic scan(input logic [6:0] b, input logic [6:0] c);
    int n, s, nb;
    s = b + c;
    nb = ((s > 127) ? 128 - b : c + 1) * 128;
    wr(`CRCCHK_OFS_BEG, {1'b0, b});
    wr(`CRCCHK_OFS_CNT, {1'b0, c});
    wr(`CRCCHK_OFS_CTRL, 8'h00);
    n_rd = 0;
    wr(`CRCCHK_OFS_CTRL, 8'h02);
    n = 0;
    @(negedge hclk);
    while (cpu_stall === 1'b1 && n < 5000) begin
      n++;
      @(negedge hclk);
    end
    for (int i = 0; i < nb; i++)
      crc_e = f(crc_e, rom_byte(14'(b * 128 + i)));
    chk(n, nb + 1);
    chk(first_a, b * 128);
    chk(n_rd, nb);
    @(posedge hclk);
    rdchk(`CRCCHK_OFS_CTRL, 8'h10);
    rdcrc();
    rdchk(`CRCCHK_OFS_ISTAT, 8'h01);
    chk(irq, 1'b1);
    wr(`CRCCHK_OFS_ISTAT, 8'h01);
    $display("test scan %h+%h done", b, c);
  endtask

  // fetch monitor: ascending addresses, first address and byte count of each scan
  always @(posedge hclk) begin
    cyc++;
    if (rom_req.rd === 1'b1) begin
      if (n_rd == 0) first_a = rom_req.addr;
      else chk(rom_req.addr, next_a);
      next_a = rom_req.addr + 14'h0001;
      n_rd++;
    end
    if (cyc == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(`CRCCHK_OFS_CTRL, 8'h10);
    for (int i = 1; i < 8; i++)
      rdchk(8'(i * 4), 8'h00);
    chk(cpu_stall, 1'b0);
    chk(hresp, 1'b0);
    chk(irq, 1'b0);
    $display("test reset done");
    wr(`CRCCHK_OFS_CTRL, 8'h0c);
    rdchk(`CRCCHK_OFS_CTRL, 8'h14);
    crc_e = `CRCCHK_SEED1;
    rdcrc();
    wr(`CRCCHK_OFS_CTRL, 8'h08);
    crc_e = `CRCCHK_SEED0;
    rdcrc();
    wr(`CRCCHK_OFS_DIN, 8'h01);
    crc_e = `CRCCHK_POLY;
    rdcrc();
    $display("test seed done");
    wr(`CRCCHK_OFS_DR, 8'h34);
    wr(`CRCCHK_OFS_CTRL, 8'h01);
    wr(`CRCCHK_OFS_DR, 8'h12);
    wr(`CRCCHK_OFS_CTRL, 8'h00);
    crc_e = 16'h1234;
    rdcrc();
    for (int i = 0; i < 9; i++) begin
      wr(`CRCCHK_OFS_DIN, 8'h31 + 8'(i));
      crc_e = f(crc_e, 8'h31 + 8'(i));
    end
    rdchk(`CRCCHK_OFS_DIN, 8'h00);
    rdcrc();
    $display("test bytes done");
    rdchk(`CRCCHK_OFS_ISTAT, 8'h02);
    chk(irq, 1'b0);
    wr(`CRCCHK_OFS_IMASK, 8'h02);
    rdchk(`CRCCHK_OFS_IMASK, 8'h02);
    chk(irq, 1'b1);
    wr(`CRCCHK_OFS_ISTAT, 8'h02);
    rdchk(`CRCCHK_OFS_ISTAT, 8'h00);
    chk(irq, 1'b0);
    wr(`CRCCHK_OFS_IMASK, 8'h01);
    $display("test irq done");
    wr(`CRCCHK_OFS_CTRL, 8'h0c);
    crc_e = `CRCCHK_SEED1;
    scan(7'h05, 7'h01);
    scan(7'h3c, 7'h00);
    scan(7'h7f, 7'h01);
    scan(7'h7e, 7'h7f);
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
